// [core/tlip_ctrl.sv]
// Purpose: interrupt enable, two-level priority and call sequencing
// Assumes: cpu pulses instr_done at each instruction boundary, return_from_interrupt with it
// Notes:   pending flags come from the peripherals, written or set by hw
`timescale 1ns/1ps
module tlip_ctrl
	import tlip_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// register bus
	input  wire logic [7:0]        sfr_addr,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [7:0]        sfr_wdata,
	output logic      [7:0]        sfr_rdata_q,
	// pending flags, index is the source rank
	input  wire logic [NUM_SRC-1:0] irq_pend,
	// cpu sequencer
	input  wire logic              cpu_instr_done,
	input  wire logic              cpu_return_from_interrupt,
	input  wire logic              cpu_call_ack,
	output logic                   call_req_q,
	output logic      [15:0]       call_vector_q,
	output logic      [RANK_W-1:0] call_rank_q,
	output logic                   call_prio_hi_q,
	output logic                   long_call_to_vector_busy_q,
	// in-service markers
	output logic                   in_service_hi_q,
	output logic                   in_service_lo_q
);

	logic [7:0]        ie_main, ip_main, ie_ext1, ie_ext2, ip_ext1, ip_ext2;
	logic [NUM_SRC-1:0] src_en, src_hi, elig, elig_hi, elig_lo;
	logic              hi_valid, lo_valid, hi_ok, lo_ok;
	logic [RANK_W-1:0] hi_idx, lo_idx;
	tlip_state_e       state_q, state_d;
	logic [2:0]        long_call_to_vector_cnt_q, long_call_to_vector_cnt_d;
	logic              call_req_d, call_prio_hi_d, long_call_to_vector_busy_d;
	logic [15:0]       call_vector_d;
	logic [RANK_W-1:0] call_rank_d;
	logic              in_service_hi_d, in_service_lo_d;
	logic [7:0]        sfr_rdata_d;
	logic              return_from_interrupt_seen;

	// address decode ignores the page select entirely
	tlip_sfr_reg #(.RESET(RST_IE_MAIN), .WMASK(WMASK_FULL)) u_ie_main (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IE_MAIN),
		.wdata   (sfr_wdata),
		.value_q (ie_main)
	);
	tlip_sfr_reg #(.RESET(RST_IP_MAIN), .WMASK(WMASK_IP_MAIN)) u_ip_main (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IP_MAIN),
		.wdata   (sfr_wdata),
		.value_q (ip_main)
	);
	tlip_sfr_reg #(.RESET(RST_IE_EXT1), .WMASK(WMASK_FULL)) u_ie_ext1 (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IE_EXT1),
		.wdata   (sfr_wdata),
		.value_q (ie_ext1)
	);
	tlip_sfr_reg #(.RESET(RST_IE_EXT2), .WMASK(WMASK_EXT2)) u_ie_ext2 (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IE_EXT2),
		.wdata   (sfr_wdata),
		.value_q (ie_ext2)
	);
	tlip_sfr_reg #(.RESET(RST_IP_EXT1), .WMASK(WMASK_FULL)) u_ip_ext1 (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IP_EXT1),
		.wdata   (sfr_wdata),
		.value_q (ip_ext1)
	);
	tlip_sfr_reg #(.RESET(RST_IP_EXT2), .WMASK(WMASK_EXT2)) u_ip_ext2 (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (sfr_wr && sfr_addr == ADDR_IP_EXT2),
		.wdata   (sfr_wdata),
		.value_q (ip_ext2)
	);

	// per-rank enable and priority; rank 19 has no bit and stays off
	assign src_en = {ie_ext2[BIT_EXT2_UART], 1'b0, ie_ext2[4:0], ie_ext1, ie_main[5:0]};
	assign src_hi = {ip_ext2[BIT_EXT2_UART], 1'b0, ip_ext2[4:0], ip_ext1, ip_main[5:0]};

	// raw pending taken every clock, whoever set it
	assign elig    = irq_pend & src_en & {NUM_SRC{ie_main[BIT_GLOBAL_EN]}};
	assign elig_hi = elig & src_hi;
	assign elig_lo = elig & ~src_hi;

	tlip_prio_pick #(.N(NUM_SRC), .W(RANK_W)) u_pick_hi (
		.req   (elig_hi),
		.valid (hi_valid),
		.idx   (hi_idx)
	);
	tlip_prio_pick #(.N(NUM_SRC), .W(RANK_W)) u_pick_lo (
		.req   (elig_lo),
		.valid (lo_valid),
		.idx   (lo_idx)
	);

	// a high routine blocks all; a low routine blocks only low
	assign hi_ok = hi_valid && !in_service_hi_q;
	assign lo_ok = lo_valid && !in_service_hi_q && !in_service_lo_q;
	assign return_from_interrupt_seen = cpu_instr_done && cpu_return_from_interrupt;

	// call sequencer and in-service markers
	always_comb begin
		state_d         = state_q;
		long_call_to_vector_cnt_d     = long_call_to_vector_cnt_q;
		call_req_d      = call_req_q;
		call_vector_d   = call_vector_q;
		call_rank_d     = call_rank_q;
		call_prio_hi_d  = call_prio_hi_q;
		long_call_to_vector_busy_d    = long_call_to_vector_busy_q;
		in_service_hi_d = in_service_hi_q;
		in_service_lo_d = in_service_lo_q;
		case (state_q)
			ST_IDLE: begin
				if (return_from_interrupt_seen) begin
					// clear the highest marker, then let one instruction run
					if (in_service_hi_q) begin
						in_service_hi_d = 1'b0;
					end else begin
						in_service_lo_d = 1'b0;
					end
					state_d = ST_RETURN_FROM_INTERRUPT_WAIT;
				end else if (hi_ok) begin
					// high wins before any low in the same cycle
					call_req_d     = 1'b1;
					call_rank_d    = hi_idx;
					call_vector_d  = VEC_BASE + (16'(hi_idx) << VEC_SHIFT);
					call_prio_hi_d = 1'b1;
					state_d        = ST_CALL;
				end else if (lo_ok) begin
					call_req_d     = 1'b1;
					call_rank_d    = lo_idx;
					call_vector_d  = VEC_BASE + (16'(lo_idx) << VEC_SHIFT);
					call_prio_hi_d = 1'b0;
					state_d        = ST_CALL;
				end
			end
			ST_CALL: begin
				// held until the cpu takes it; a cache miss just delays the ack
				if (cpu_call_ack) begin
					call_req_d   = 1'b0;
					long_call_to_vector_busy_d = 1'b1;
					long_call_to_vector_cnt_d  = '0;
					state_d      = ST_LONG_CALL_TO_VECTOR;
					if (call_prio_hi_q) begin
						in_service_hi_d = 1'b1;
					end else begin
						in_service_lo_d = 1'b1;
					end
				end
			end
			ST_LONG_CALL_TO_VECTOR: begin
				if (long_call_to_vector_cnt_q == LONG_CALL_TO_VECTOR_LAST) begin
					long_call_to_vector_busy_d = 1'b0;
					state_d      = ST_IDLE;
				end else begin
					long_call_to_vector_cnt_d = long_call_to_vector_cnt_q + 3'h1;
				end
			end
			ST_RETURN_FROM_INTERRUPT_WAIT: begin
				// the instruction after the return completes before any call
				if (cpu_instr_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q         <= ST_IDLE;
			long_call_to_vector_cnt_q     <= '0;
			call_req_q      <= 1'b0;
			call_vector_q   <= VEC_RESET;
			call_rank_q     <= '0;
			call_prio_hi_q  <= 1'b0;
			long_call_to_vector_busy_q    <= 1'b0;
			in_service_hi_q <= 1'b0;
			in_service_lo_q <= 1'b0;
		end else begin
			state_q         <= state_d;
			long_call_to_vector_cnt_q     <= long_call_to_vector_cnt_d;
			call_req_q      <= call_req_d;
			call_vector_q   <= call_vector_d;
			call_rank_q     <= call_rank_d;
			call_prio_hi_q  <= call_prio_hi_d;
			long_call_to_vector_busy_q    <= long_call_to_vector_busy_d;
			in_service_hi_q <= in_service_hi_d;
			in_service_lo_q <= in_service_lo_d;
		end
	end

	// read data one clock after the strobe; foreign addresses give zero
	always_comb begin
		sfr_rdata_d = sfr_rdata_q;
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_IE_MAIN: sfr_rdata_d = ie_main;
				ADDR_IP_MAIN: sfr_rdata_d = ip_main;
				ADDR_IE_EXT1: sfr_rdata_d = ie_ext1;
				ADDR_IE_EXT2: sfr_rdata_d = ie_ext2;
				ADDR_IP_EXT1: sfr_rdata_d = ip_ext1;
				ADDR_IP_EXT2: sfr_rdata_d = ip_ext2;
				default:      sfr_rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata_q <= 8'h00;
		end else begin
			sfr_rdata_q <= sfr_rdata_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_HI_BLOCKS: assert property (
		(state_q == ST_IDLE && in_service_hi_q && !return_from_interrupt_seen) |=> state_q != ST_CALL
	) else $error("call started while high routine in service");

	AST_HI_PREEMPTS: assert property (
		(state_q == ST_IDLE && !return_from_interrupt_seen && hi_valid && in_service_lo_q && !in_service_hi_q)
		|=> (call_req_q && call_prio_hi_q)
	) else $error("high request did not preempt low routine");

	AST_HI_FIRST: assert property (
		(state_q == ST_IDLE && !return_from_interrupt_seen && hi_ok && lo_valid) |=> call_rank_q == $past(hi_idx)
	) else $error("low request served ahead of high");

	AST_GLOBAL_GATE: assert property (
		(state_q == ST_IDLE && !ie_main[BIT_GLOBAL_EN]) |=> !call_req_q
	) else $error("call raised with global enable off");

	AST_VECTOR: assert property (
		call_req_q |-> (call_vector_q == VEC_BASE + (16'(call_rank_q) << VEC_SHIFT)
			&& call_rank_q != RSVD_RANK)
	) else $error("vector does not match rank");

	AST_LONG_CALL_TO_VECTOR_LEN: assert property (
		(state_q == ST_CALL && cpu_call_ack) |=> long_call_to_vector_busy_q [*4] ##1 !long_call_to_vector_busy_q
	) else $error("long call not four cycles");

	AST_RETURN_FROM_INTERRUPT_ONE_MORE: assert property (
		(state_q == ST_IDLE && return_from_interrupt_seen) |=> !call_req_q ##0 (!call_req_q throughout (state_q == ST_RETURN_FROM_INTERRUPT_WAIT [*1]))
	) else $error("call raised before instruction after return");

	AST_MARK_SET: assert property (
		(state_q == ST_CALL && cpu_call_ack && call_prio_hi_q) |=> in_service_hi_q
	) else $error("high marker not set on call");

	AST_IP_TOP_ONES: assert property (
		ip_main[7:6] == 2'b11 && ip_ext2[7] == 1'b0 && ip_ext2[5] == 1'b0
	) else $error("fixed priority bits moved");

	AST_EXT2_UNUSED: assert property (
		$past(sfr_wr) |-> (ie_ext2[7] == 1'b0 && ie_ext2[5] == 1'b0)
	) else $error("unused enable bits written");

	COV_LOW_CALL:  cover property (state_q == ST_CALL && !call_prio_hi_q ##1 long_call_to_vector_busy_q);
	COV_PREEMPT:   cover property (in_service_lo_q && state_q == ST_CALL && call_prio_hi_q);
	COV_RETURN_FROM_INTERRUPT_WAIT: cover property (state_q == ST_RETURN_FROM_INTERRUPT_WAIT ##1 state_q == ST_IDLE ##1 call_req_q);

endmodule

// [core/tlip_pkg.sv]
// Purpose: shared constants for the two-level interrupt priority block
// Assumes: one 125 MHz system clock, special-function-register byte bus
// Notes:   source ranks 0..20, rank 19 has no source
package tlip_pkg;

	// source count and rank width
	localparam int unsigned NUM_SRC    = 21;
	localparam int unsigned RANK_W     = 5;
	localparam logic [4:0]  RSVD_RANK  = 5'h13;

	// register addresses, identical on every register page
	localparam logic [7:0] ADDR_IE_MAIN  = 8'ha8;
	localparam logic [7:0] ADDR_IP_MAIN  = 8'hb8;
	localparam logic [7:0] ADDR_IE_EXT1  = 8'he6;
	localparam logic [7:0] ADDR_IE_EXT2  = 8'he7;
	localparam logic [7:0] ADDR_IP_EXT1  = 8'hf6;
	localparam logic [7:0] ADDR_IP_EXT2  = 8'hf7;

	// reset values
	localparam logic [7:0] RST_IE_MAIN   = 8'h00;
	localparam logic [7:0] RST_IP_MAIN   = 8'hc0;
	localparam logic [7:0] RST_IE_EXT1   = 8'h00;
	localparam logic [7:0] RST_IE_EXT2   = 8'h00;
	localparam logic [7:0] RST_IP_EXT1   = 8'h00;
	localparam logic [7:0] RST_IP_EXT2   = 8'h00;

	// writable bit masks; bits outside keep their reset value
	localparam logic [7:0] WMASK_FULL    = 8'hff;
	localparam logic [7:0] WMASK_IP_MAIN = 8'h3f;
	localparam logic [7:0] WMASK_EXT2    = 8'h5f;

	// field positions: global and spare in the main enable register, uart in the second extended registers
	localparam int unsigned BIT_GLOBAL_EN = 7;
	localparam int unsigned BIT_SPARE     = 6;
	localparam int unsigned BIT_EXT2_UART = 6;

	// vectors: base plus rank times eight
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam int unsigned VEC_SHIFT = 3;

	// call timing in system clocks
	localparam int unsigned DETECT_CYCLES = 1;
	localparam int unsigned LONG_CALL_TO_VECTOR_CYCLES  = 4;
	localparam logic [2:0]  LONG_CALL_TO_VECTOR_LAST    = 3'(LONG_CALL_TO_VECTOR_CYCLES - 1);

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_CALL      = 2'b01,
		ST_LONG_CALL_TO_VECTOR     = 2'b10,
		ST_RETURN_FROM_INTERRUPT_WAIT = 2'b11
	} tlip_state_e;

endpackage

// [core/tlip_sfr_reg.sv]
// Purpose: one byte-wide interrupt control register
// Assumes: write strobe already qualified by address
// Notes:   bits outside WMASK hold RESET forever, so they read fixed
`timescale 1ns/1ps
module tlip_sfr_reg #(
	parameter logic [7:0] RESET = 8'h00,
	parameter logic [7:0] WMASK = 8'hff
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// write side
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	// stored value
	output logic      [7:0] value_q
);

	logic [7:0] value_d;

	// masked write; fixed bits never move
	always_comb begin
		value_d = value_q;
		if (wr_en) begin
			value_d = (wdata & WMASK) | (RESET & ~WMASK);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			value_q <= RESET;
		end else begin
			value_q <= value_d;
		end
	end

endmodule

// [core/tlip_prio_pick.sv]
// Purpose: fixed-order picker, lowest index wins
// Assumes: request vector already gated by enables
// Notes:   purely combinational
`timescale 1ns/1ps
module tlip_prio_pick #(
	parameter int unsigned N = 21,
	parameter int unsigned W = 5
) (
	// requests
	input  wire logic [N-1:0] req,
	// winner
	output logic              valid,
	output logic      [W-1:0] idx
);

	// scan downward so the lowest set index is the last to land
	always_comb begin
		valid = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				valid = 1'b1;
				idx   = W'(i);
			end
		end
	end

endmodule

// [verification/tlip_cpu_model.sv]
// Purpose: cpu sequencer model facing the interrupt block
// Assumes: bench drives step_cmd and ret_cmd at the falling edge
// Notes:   takes every call after ack_delay cycles, as a cache miss would
`timescale 1ns/1ps
module tlip_cpu_model (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// bench commands
	input  wire logic [3:0] ack_delay,
	input  wire logic       step_cmd,
	input  wire logic       ret_cmd,
	// call side of the block
	input  wire logic       call_req_q,
	input  wire logic       long_call_to_vector_busy_q,
	output logic            cpu_call_ack,
	output logic            cpu_instr_done,
	output logic            cpu_return_from_interrupt
);
	logic [3:0] wait_q;

	// a real core cannot return while a call is still on its way
	assign cpu_return_from_interrupt       = ret_cmd & ~call_req_q & ~long_call_to_vector_busy_q;
	assign cpu_instr_done = step_cmd | cpu_return_from_interrupt;

	// ack on the falling edge so the block samples a settled pulse
	always @(negedge clock or negedge rstn) begin
		if (!rstn) begin
			cpu_call_ack <= 1'b0;
			wait_q       <= 4'h0;
		end else begin
			cpu_call_ack <= 1'b0;
			if (call_req_q && !cpu_call_ack) begin
				if (wait_q == ack_delay) begin
					cpu_call_ack <= 1'b1;
					wait_q       <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule

// [verification/tlip_ctrl_tb.sv]
// Purpose: self-checking bench for the two-level interrupt priority block
// Assumes: cpu model acks calls; bench drives all inputs at the falling edge
// Notes:   expectations come from package constants, never from outputs
`timescale 1ns/1ps
module tlip_ctrl_tb
	import tlip_pkg::*;
();
	logic               clock, rstn, sfr_wr, sfr_rd, step_cmd, ret_cmd;
	logic [7:0]         sfr_addr, sfr_wdata, sfr_rdata_q, rv;
	logic [NUM_SRC-1:0] irq_pend;
	logic [3:0]         ack_delay;
	logic               cpu_instr_done, cpu_return_from_interrupt, cpu_call_ack, call_req_q;
	logic               call_prio_hi_q, long_call_to_vector_busy_q, in_service_hi_q, in_service_lo_q;
	logic [15:0]        call_vector_q;
	logic [RANK_W-1:0]  call_rank_q;
	int                 fails, n_tests;
	logic [7:0]         addrs [6] = '{ADDR_IE_MAIN, ADDR_IP_MAIN, ADDR_IE_EXT1, ADDR_IE_EXT2, ADDR_IP_EXT1, ADDR_IP_EXT2};
	logic [7:0]         rsts [6]  = '{RST_IE_MAIN, RST_IP_MAIN, RST_IE_EXT1, RST_IE_EXT2, RST_IP_EXT1, RST_IP_EXT2};
	logic [7:0]         masks [6] = '{WMASK_FULL, WMASK_IP_MAIN, WMASK_FULL, WMASK_EXT2, WMASK_FULL, WMASK_EXT2};

	tlip_ctrl uut (.clock(clock), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .irq_pend(irq_pend), .cpu_instr_done(cpu_instr_done),
		.cpu_return_from_interrupt(cpu_return_from_interrupt), .cpu_call_ack(cpu_call_ack), .call_req_q(call_req_q), .call_vector_q(call_vector_q),
		.call_rank_q(call_rank_q), .call_prio_hi_q(call_prio_hi_q), .long_call_to_vector_busy_q(long_call_to_vector_busy_q),
		.in_service_hi_q(in_service_hi_q), .in_service_lo_q(in_service_lo_q));

	tlip_cpu_model cpu (.clock(clock), .rstn(rstn), .ack_delay(ack_delay), .step_cmd(step_cmd),
		.ret_cmd(ret_cmd), .call_req_q(call_req_q), .long_call_to_vector_busy_q(long_call_to_vector_busy_q), .cpu_call_ack(cpu_call_ack),
		.cpu_instr_done(cpu_instr_done), .cpu_return_from_interrupt(cpu_return_from_interrupt));

	// free-running system clock, 8 ns
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic complete_run();
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one-cycle strobes; a gap cycle keeps back-to-back calls apart
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr  = a;
		sfr_wdata = d;
		sfr_wr    = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd   = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		v      = sfr_rdata_q;
	endtask

	task automatic pulse(input bit is_ret);
		@(negedge clock);
		ret_cmd  = is_ret;
		step_cmd = !is_ret;
		@(negedge clock);
		ret_cmd  = 1'b0;
		step_cmd = 1'b0;
	endtask

	task automatic no_call(input int k);
		repeat (k) begin
			@(negedge clock);
			chk("call_req idle", 16'h0, call_req_q);
		end
	endtask

	// waits for a call, checks its fields, latency and the long call window
	task automatic take(input int r, input bit hi);
		int n;
		int busy;
		n    = 0;
		busy = 0;
		while (call_req_q !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 20) begin
				fails++;
				complete_run();
			end
		end
		chk("detect in one cycle", 16'h1, 16'(n == 1));
		chk("vector", VEC_BASE + 16'(r << VEC_SHIFT), call_vector_q);
		chk("rank", 16'(r), 16'(call_rank_q));
		chk("prio", 16'(hi), 16'(call_prio_hi_q));
		repeat (10) begin
			@(negedge clock);
			busy += int'(long_call_to_vector_busy_q === 1'b1);
		end
		chk("long call cycles", 16'(LONG_CALL_TO_VECTOR_CYCLES), 16'(busy));
		chk("marker", 16'h1, hi ? 16'(in_service_hi_q) : 16'(in_service_lo_q));
	endtask

	task automatic s_regs();
		for (int i = 0; i < 6; i++) begin
			rd(addrs[i], rv);
			chk("reset value", 16'(rsts[i]), 16'(rv));
			wr(addrs[i], 8'hff);
			rd(addrs[i], rv);
			chk("ones written", 16'((8'hff & masks[i]) | (rsts[i] & ~masks[i])), 16'(rv));
			wr(addrs[i], 8'h00);
			rd(addrs[i], rv);
			chk("zeros written", 16'(rsts[i] & ~masks[i]), 16'(rv));
		end
		wr(8'ha9, 8'hff);
		rd(ADDR_IE_MAIN, rv);
		chk("unmapped write", 16'h0, 16'(rv));
		rd(8'ha9, rv);
		chk("unmapped read", 16'h0, 16'(rv));
	endtask

	task automatic s_gate();
		wr(ADDR_IE_MAIN, 8'h02);
		irq_pend[1] = 1'b1;
		no_call(6);
		wr(ADDR_IE_MAIN, 8'h80);
		no_call(6);
		wr(ADDR_IE_MAIN, 8'h82);
		take(1, 1'b0);
		irq_pend = '0;
		pulse(1'b1);
		chk("lo marker cleared", 16'h0, 16'(in_service_lo_q));
		pulse(1'b0);
	endtask

	// every source vectors in turn; the reserved rank never calls
	task automatic s_vectors();
		wr(ADDR_IE_MAIN, 8'hbf);
		wr(ADDR_IE_EXT1, 8'hff);
		wr(ADDR_IE_EXT2, 8'h5f);
		for (int r = 0; r < NUM_SRC; r++) begin
			if (r != int'(RSVD_RANK)) begin
				irq_pend[r] = 1'b1;
				take(r, 1'b0);
				irq_pend = '0;
				pulse(1'b1);
				pulse(1'b0);
			end
		end
		irq_pend[19] = 1'b1;
		no_call(6);
		irq_pend = '0;
	endtask

	task automatic s_arb();
		wr(ADDR_IE_MAIN, 8'h8b);
		wr(ADDR_IP_MAIN, 8'h08);
		irq_pend[1] = 1'b1;
		irq_pend[3] = 1'b1;
		take(3, 1'b1);
		no_call(8);
		irq_pend[3] = 1'b0;
		pulse(1'b1);
		no_call(4);
		pulse(1'b0);
		take(1, 1'b0);
		irq_pend = '0;
		pulse(1'b1);
		pulse(1'b0);
		wr(ADDR_IP_MAIN, 8'h00);
		irq_pend[1] = 1'b1;
		irq_pend[3] = 1'b1;
		take(1, 1'b0);
		irq_pend = '0;
		pulse(1'b1);
		pulse(1'b0);
	endtask

	// slow ack stands in for a cache miss on the vector fetch
	task automatic s_preempt();
		ack_delay = 4'h3;
		wr(ADDR_IP_MAIN, 8'h08);
		irq_pend[1] = 1'b1;
		take(1, 1'b0);
		irq_pend[0] = 1'b1;
		no_call(6);
		irq_pend[3] = 1'b1;
		take(3, 1'b1);
		chk("lo marker kept", 16'h1, 16'(in_service_lo_q));
		irq_pend = '0;
		pulse(1'b1);
		chk("hi marker cleared", 16'h0, 16'(in_service_hi_q));
		chk("lo marker stays", 16'h1, 16'(in_service_lo_q));
		pulse(1'b0);
		pulse(1'b1);
		chk("lo marker cleared", 16'h0, 16'(in_service_lo_q));
	endtask

	// reset in mid-routine drops markers, enables and priorities
	task automatic s_reset();
		pulse(1'b0);
		irq_pend[3] = 1'b1;
		take(3, 1'b1);
		rstn = 1'b0;
		@(negedge clock);
		rstn = 1'b1;
		chk("hi marker after reset", 16'h0, 16'(in_service_hi_q));
		no_call(4);
		rd(ADDR_IP_MAIN, rv);
		chk("prio after reset", 16'(RST_IP_MAIN), 16'(rv));
		irq_pend = '0;
	endtask

	initial begin
		fails     = 0;
		n_tests   = 0;
		rstn      = 1'b0;
		sfr_wr    = 1'b0;
		sfr_rd    = 1'b0;
		sfr_addr  = 8'h00;
		sfr_wdata = 8'h00;
		irq_pend  = '0;
		step_cmd  = 1'b0;
		ret_cmd   = 1'b0;
		ack_delay = 4'h0;
		repeat (4) @(negedge clock);
		rstn = 1'b1;
		chk("vector after reset", VEC_RESET, call_vector_q);
		s_regs();
		s_gate();
		s_vectors();
		s_arb();
		s_preempt();
		s_reset();
		complete_run();
	end
endmodule
